// [rtl/adcs_pkg.sv]
package adcs_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned RES_W  = 10;
    localparam int unsigned CH_W   = 5;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_SC1   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SC2   = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_RH    = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_RL    = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CVH   = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CVL   = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_CFG   = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_ISTAT = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_IMASK = 4'h9;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned SC1_CONVERSION_COMPLETE_FLAG = 7;
    localparam int unsigned SC1_IEN  = 6;
    localparam int unsigned SC1_CONT = 5;
    localparam int unsigned SC2_ACT  = 7;
    localparam int unsigned SC2_CMPE = 5;
    localparam int unsigned SC2_CMPG = 4;
    localparam int unsigned CFG_LP   = 7;
    localparam int unsigned CFG_LSMP = 4;
    localparam int unsigned CFG_MODE = 2;
    localparam int unsigned CFG_CLK  = 0;
    localparam int unsigned IRQ_DONE = 0;
    localparam int unsigned IRQ_LOST = 1;
    localparam int unsigned IRQ_W    = 2;

    localparam logic [CH_W-1:0] CH_OFF     = 5'h1F;
    localparam logic [1:0]      MODE_TEN   = 2'h1;
    localparam logic [1:0]      CLK_ASYNC  = 2'h3;
    localparam logic [CH_W-1:0] CH_RESET   = 5'h1F;

    // ------------------------------------------------------------
    // timing: tick base in bus cycles, sample lengths in conversion-clock ticks
    // ------------------------------------------------------------
    localparam logic [7:0] TICK_BASE   = 8'h04;
    localparam logic [4:0] SAMPLE_SHORT = 5'h04;
    localparam logic [4:0] SAMPLE_LONG  = 5'h14;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcs_state_t;

    typedef struct packed {
        logic             active;
        logic             async_clk_en;
        logic             low_power;
        logic             sample;
        logic             ten_bit;
        logic [CH_W-1:0]  channel;
        logic [RES_W-1:0] dac_code;
    } adcs_core_t;

endpackage

// [rtl/adcs_sequencer.sv]
`timescale 1ns/1ps

module adcs_sequencer (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_arst_n,
    input  wire logic [adcs_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [adcs_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [adcs_pkg::DATA_W-1:0] o_rdata,
    input  wire logic                        i_stop_mode,
    input  wire logic                        i_cmp_above,
    output adcs_pkg::adcs_core_t             o_core,
    output logic                             o_irq
);
    import adcs_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    adcs_state_t        state_q;
    logic               conversion_complete_flag_q;
    logic               ien_q;
    logic               cont_q;
    logic [CH_W-1:0]    ch_q;
    logic               cmpe_q;
    logic               cmpg_q;
    logic [DATA_W-1:0]  cvh_q;
    logic [DATA_W-1:0]  cvl_q;
    logic [DATA_W-1:0]  cfg_q;
    logic [DATA_W-1:0]  rh_q;
    logic [DATA_W-1:0]  rl_q;
    logic               lock_q;
    logic [IRQ_W-1:0]   istat_q;
    logic [IRQ_W-1:0]   imask_q;
    logic [DATA_W-1:0]  rdata_q;
    logic               irq_q;
    adcs_core_t         core_q;
    logic [7:0]         tick_cnt_q;
    logic [4:0]         samp_cnt_q;
    logic [3:0]         bit_q;
    logic [RES_W-1:0]   sar_q;
    logic               cmp_meta_q;
    logic               cmp_sync_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic wr_sc1;
    logic wr_mode;
    logic rd_rh;
    logic rd_rl;
    logic ten_bit;
    logic async_sel;
    logic stop_abort;
    logic start_sc1;

    assign wr_sc1    = i_wr && (i_addr == OFS_SC1);
    assign wr_mode   = i_wr && (i_addr == OFS_SC2 || i_addr == OFS_CFG ||
                                i_addr == OFS_CVH || i_addr == OFS_CVL);
    assign rd_rh     = i_rd && (i_addr == OFS_RH);
    assign rd_rl     = i_rd && (i_addr == OFS_RL);
    assign ten_bit   = (cfg_q[CFG_MODE +: 2] == MODE_TEN);
    assign async_sel = (cfg_q[CFG_CLK +: 2] == CLK_ASYNC);
    // async clock keeps running in stop, so only the other sources abort
    assign stop_abort = i_stop_mode && !async_sel;
    assign start_sc1  = wr_sc1 && (i_wdata[CH_W-1:0] != CH_OFF);

    // ------------------------------------------------------------
    // comparator synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else begin
            cmp_meta_q <= i_cmp_above;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // ------------------------------------------------------------
    // conversion clock tick
    // ------------------------------------------------------------
    // the lowest divide still leaves four bus cycles per step, enough
    // for the comparator to cross the synchroniser
    logic [2:0] div_sh;
    logic [7:0] tick_lim;
    logic       tick;

    assign div_sh   = {1'b0, cfg_q[CFG_CLK +: 2]} + {2'b00, cfg_q[CFG_LP]};
    assign tick_lim = TICK_BASE << div_sh;
    assign tick     = (state_q != ST_IDLE) && (tick_cnt_q == tick_lim - 8'h01);

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_cnt_q <= 8'h00;
        end else if (state_q == ST_IDLE || tick) begin
            tick_cnt_q <= 8'h00;
        end else begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // approximation step and completion
    // ------------------------------------------------------------
    logic [RES_W-1:0] one_hot;
    logic [RES_W-1:0] sar_kept;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] cmp_val;
    logic             cmp_true;
    logic             fin;
    logic             blocked;
    logic             fin_xfer;
    logic             fin_lost;
    logic             fin_again;

    assign one_hot  = RES_W'(1) << bit_q;
    assign sar_kept = cmp_sync_q ? sar_q : (sar_q & ~one_hot);
    assign result   = ten_bit ? sar_kept : {2'b00, sar_kept[7:0]};
    assign cmp_val  = ten_bit ? {cvh_q[1:0], cvl_q} : {2'b00, cvl_q};
    assign cmp_true = !cmpe_q || (cmpg_q ? (result >= cmp_val) : (result < cmp_val));
    assign fin      = (state_q == ST_CONVERT) && tick && (bit_q == 4'h0);
    assign blocked  = ten_bit && lock_q;
    assign fin_xfer = fin && !blocked && cmp_true;
    assign fin_lost = fin && blocked;

    always_comb begin
        if (blocked) begin
            // a failed compare in single mode stops despite the lock
            fin_again = fin && !(!cont_q && cmpe_q && !cmp_true);
        end else begin
            fin_again = fin && cont_q;
        end
    end

    logic [3:0] top_bit;
    assign top_bit = ten_bit ? 4'h9 : 4'h7;

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q    <= ST_IDLE;
            samp_cnt_q <= 5'h00;
            bit_q      <= 4'h0;
            sar_q      <= '0;
        end else if (start_sc1) begin
            state_q    <= ST_SAMPLE;
            samp_cnt_q <= 5'h00;
        end else if (wr_sc1 || wr_mode || stop_abort) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        if (samp_cnt_q == (cfg_q[CFG_LSMP] ? SAMPLE_LONG : SAMPLE_SHORT) - 5'h01) begin
                            state_q <= ST_CONVERT;
                            bit_q   <= top_bit;
                            sar_q   <= RES_W'(1) << top_bit;
                        end else begin
                            samp_cnt_q <= samp_cnt_q + 5'h01;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (fin) begin
                        state_q    <= fin_again ? ST_SAMPLE : ST_IDLE;
                        samp_cnt_q <= 5'h00;
                    end else if (tick) begin
                        bit_q <= bit_q - 4'h1;
                        sar_q <= sar_kept | (one_hot >> 1);
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // result bytes, lock and complete flag
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rh_q <= '0;
            rl_q <= '0;
        end else if (fin_xfer) begin
            // aborts before the last step never reach here, so the last good result stays
            rh_q <= ten_bit ? {6'h00, sar_kept[9:8]} : 8'h00;
            rl_q <= sar_kept[7:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lock_q <= 1'b0;
        end else if (rd_rl) begin
            lock_q <= 1'b0;
        end else if (rd_rh && ten_bit) begin
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            conversion_complete_flag_q <= 1'b0;
        end else if (fin_xfer) begin
            conversion_complete_flag_q <= 1'b1;
        end else if (wr_sc1 || rd_rl) begin
            conversion_complete_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ien_q   <= 1'b0;
            cont_q  <= 1'b0;
            ch_q    <= CH_RESET;
            cmpe_q  <= 1'b0;
            cmpg_q  <= 1'b0;
            cvh_q   <= '0;
            cvl_q   <= '0;
            cfg_q   <= '0;
            imask_q <= '0;
        end else if (i_wr) begin
            case (i_addr)
                OFS_SC1: begin
                    ien_q  <= i_wdata[SC1_IEN];
                    cont_q <= i_wdata[SC1_CONT];
                    ch_q   <= i_wdata[CH_W-1:0];
                end
                OFS_SC2: begin
                    cmpe_q <= i_wdata[SC2_CMPE];
                    cmpg_q <= i_wdata[SC2_CMPG];
                end
                OFS_CVH:   cvh_q   <= i_wdata;
                OFS_CVL:   cvl_q   <= i_wdata;
                OFS_CFG:   cfg_q   <= i_wdata;
                OFS_IMASK: imask_q <= i_wdata[IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;

    assign ev[IRQ_DONE] = fin_xfer && ien_q;
    assign ev[IRQ_LOST] = fin_lost;
    assign w1c = (i_wr && i_addr == OFS_ISTAT) ? i_wdata[IRQ_W-1:0] : '0;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            istat_q <= '0;
        end else begin
            // a new event outranks a clear in the same cycle
            istat_q <= (istat_q & ~w1c) | ev;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(istat_q & imask_q);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rmux;

    always_comb begin
        rmux = '0;
        case (i_addr)
            OFS_SC1: begin
                rmux[SC1_CONVERSION_COMPLETE_FLAG]   = conversion_complete_flag_q;
                rmux[SC1_IEN]    = ien_q;
                rmux[SC1_CONT]   = cont_q;
                rmux[CH_W-1:0]   = ch_q;
            end
            OFS_SC2: begin
                rmux[SC2_ACT]  = (state_q != ST_IDLE);
                rmux[SC2_CMPE] = cmpe_q;
                rmux[SC2_CMPG] = cmpg_q;
            end
            OFS_RH:    rmux = rh_q;
            OFS_RL:    rmux = rl_q;
            OFS_CVH:   rmux = cvh_q;
            OFS_CVL:   rmux = cvl_q;
            OFS_CFG:   rmux = cfg_q;
            OFS_ISTAT: rmux[IRQ_W-1:0] = istat_q;
            OFS_IMASK: rmux[IRQ_W-1:0] = imask_q;
            default:   rmux = '0;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= i_rd ? rmux : '0;
        end
    end

    // ------------------------------------------------------------
    // analog core controls
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            core_q <= '0;
        end else begin
            core_q.active       <= (state_q != ST_IDLE);
            core_q.async_clk_en <= (state_q != ST_IDLE) && async_sel;
            core_q.low_power    <= cfg_q[CFG_LP];
            core_q.sample       <= (state_q == ST_SAMPLE);
            core_q.ten_bit      <= ten_bit;
            core_q.channel      <= ch_q;
            core_q.dac_code     <= sar_q;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq   = irq_q;
    assign o_core  = core_q;

endmodule

// [testbench/adcs_sar_model.sv]
`timescale 1ns/1ps

// ----------------------------------------
// analog core: input held half a step above i_vin
// ----------------------------------------
module adcs_sar_model (
    input  wire logic                 i_sys_clk,
    input  wire adcs_pkg::adcs_core_t i_core,
    input  wire logic [9:0]           i_vin,
    output logic                      o_cmp_above
);
    import adcs_pkg::*;

    logic wander = 1'b0;

    // an idle comparator wanders, so a stale level is never trusted
    always @(posedge i_sys_clk) begin
        wander <= ~wander;
    end

    assign o_cmp_above = i_core.active ? (i_vin >= i_core.dac_code) : wander;
endmodule

// [testbench/adcs_sequencer_chk.sv]
`timescale 1ns/1ps

module adcs_sequencer_chk (
    input wire logic                        i_sys_clk,
    input wire logic                        i_arst_n,
    input wire logic [adcs_pkg::ADDR_W-1:0] i_addr,
    input wire logic [adcs_pkg::DATA_W-1:0] i_wdata,
    input wire logic                        i_wr,
    input wire logic                        i_rd,
    input wire logic [adcs_pkg::DATA_W-1:0] o_rdata,
    input wire logic                        i_stop_mode,
    input wire adcs_pkg::adcs_core_t        o_core
);
    import adcs_pkg::*;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    logic wr_sc1;
    logic wr_mode;

    assign wr_sc1  = i_wr && i_addr == OFS_SC1;
    assign wr_mode = i_wr && (i_addr == OFS_SC2 || i_addr == OFS_CFG || i_addr == OFS_CVH || i_addr == OFS_CVL);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside its answer cycle");
    a_start_sample: assert property (
        wr_sc1 && i_wdata[CH_W-1:0] != CH_OFF |-> ##2 o_core.active && o_core.sample)
        else $error("channel write did not start sampling");
    a_off_abort: assert property (
        wr_sc1 && i_wdata[CH_W-1:0] == CH_OFF |-> ##2 !o_core.active)
        else $error("channel off write did not abort");
    a_mode_abort: assert property (wr_mode |-> ##2 !o_core.active)
        else $error("mode write did not abort");
    a_stop_abort: assert property (
        i_stop_mode && o_core.active && !o_core.async_clk_en |-> ##[1:2] !o_core.active)
        else $error("stop did not abort");
    a_async_active: assert property (o_core.async_clk_en |-> o_core.active)
        else $error("async clock on while idle");
    a_begin_sample: assert property ($rose(o_core.active) |-> o_core.sample)
        else $error("activity began without sampling");
    a_sample_active: assert property (o_core.sample |-> o_core.active)
        else $error("sampling while idle");
    a_msb_first: assert property (
        $fell(o_core.sample) && o_core.active && o_core.ten_bit |-> o_core.dac_code == 10'h200)
        else $error("first trial code is not the top bit");
endmodule

bind adcs_sequencer adcs_sequencer_chk adcs_sequencer_chk_i (
    .i_sys_clk   (i_sys_clk),
    .i_arst_n    (i_arst_n),
    .i_addr      (i_addr),
    .i_wdata     (i_wdata),
    .i_wr        (i_wr),
    .i_rd        (i_rd),
    .o_rdata     (o_rdata),
    .i_stop_mode (i_stop_mode),
    .o_core      (o_core)
);

// [testbench/adcs_sequencer_test.sv]
`timescale 1ns/1ps

module adcs_sequencer_test;
    import adcs_pkg::*;

    logic              i_sys_clk   = 1'b0;
    logic              i_arst_n    = 1'b0;
    logic [ADDR_W-1:0] i_addr      = 4'h0;
    logic [DATA_W-1:0] i_wdata     = 8'h00;
    logic              i_wr        = 1'b0;
    logic              i_rd        = 1'b0;
    logic              i_stop_mode = 1'b0;
    logic [DATA_W-1:0] o_rdata;
    logic              i_cmp_above;
    adcs_core_t        o_core;
    logic              o_irq;
    logic [9:0]        vin         = 10'h000;
    logic [9:0]        res         = 10'h000;
    logic [4:0]        ch          = 5'h00;
    logic [31:0]       seed        = 32'hAFB4EAEE;
    logic [3:0]        ab_a [5]    = '{OFS_SC1, OFS_SC2, OFS_CVH, OFS_CVL, OFS_CFG};
    logic [7:0]        ab_d [5]    = '{8'h1F, 8'h00, 8'h00, 8'h00, 8'h04};
    int                n;
    int                e;
    int                fail_count  = 0;
    int                checks      = 0;

    adcs_sequencer adcs_sequencer_i (
        .i_sys_clk   (i_sys_clk),
        .i_arst_n    (i_arst_n),
        .i_addr      (i_addr),
        .i_wdata     (i_wdata),
        .i_wr        (i_wr),
        .i_rd        (i_rd),
        .o_rdata     (o_rdata),
        .i_stop_mode (i_stop_mode),
        .i_cmp_above (i_cmp_above),
        .o_core      (o_core),
        .o_irq       (o_irq)
    );

    adcs_sar_model adcs_sar_model_i (
        .i_sys_clk   (i_sys_clk),
        .i_core      (o_core),
        .i_vin       (vin),
        .o_cmp_above (i_cmp_above)
    );

    initial begin
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t register read %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t status bit %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_sys_clk);
        i_addr  <= a;
        i_wdata <= v;
        i_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_rd   <= 1'b0;
        #1;
        cmp8(o_rdata, exp);
    endtask

    // high byte read first arms the lock in ten-bit mode, low byte read releases it
    task automatic chk_res();
        chk_reg(OFS_RH, 8'(res >> 8));
        chk_reg(OFS_RL, 8'(res));
    endtask

    task automatic set_stop(input logic v);
        @(posedge i_sys_clk);
        i_stop_mode <= v;
    endtask

    // fresh random input and channel, then a start write
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        xorshift = v ^ (v << 5);
    endfunction

    task automatic launch(input logic [2:0] f);
        @(posedge i_sys_clk);
        seed = xorshift(seed);
        vin <= {1'b0, seed[8:0]};
        // bench-side copy, must hold the new channel before the write below
        ch = {1'b0, seed[19:16]};
        wr_reg(OFS_SC1, {f, ch});
    endtask

    task automatic wait_idle(input logic upd);
        n = 0;
        tick(1);
        while (o_core.active !== 1'b0 && n < 1000) begin
            tick(1);
            n++;
        end
        cmp1(n < 1000, 1'b1);
        if (upd) begin
            res = vin;
        end
    endtask

    initial begin
        #2_000_000;
        fail_count++;
        stop_test();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            chk_reg(4'(a), a == 0 ? 8'h1F : 8'h00);
        end
        wr_reg(OFS_IMASK, 8'h03);
        wr_reg(OFS_CFG, 8'h04);
        launch(3'b010);
        wait_idle(1'b1);
        chk_reg(OFS_SC1, {3'b110, ch});
        cmp8({3'b000, o_core.channel}, {3'b000, ch});
        chk_reg(OFS_ISTAT, 8'h01);
        cmp1(o_irq, 1'b1);
        wr_reg(OFS_IMASK, 8'h00);
        tick(2);
        cmp1(o_irq, 1'b0);
        wr_reg(OFS_IMASK, 8'h03);
        chk_res();
        chk_reg(OFS_SC1, {3'b010, ch});
        wr_reg(OFS_ISTAT, 8'h01);
        tick(2);
        cmp1(o_irq, 1'b0);
        launch(3'b000);
        wait_idle(1'b1);
        chk_reg(OFS_ISTAT, 8'h00);
        chk_reg(OFS_RH, 8'(res >> 8));
        launch(3'b000);
        tick(200);
        chk_reg(OFS_SC1, {3'b000, ch});
        chk_reg(OFS_ISTAT, 8'h02);
        cmp1(o_core.active, 1'b1);
        chk_reg(OFS_RL, 8'(res));
        wait_idle(1'b1);
        chk_res();
        wr_reg(OFS_ISTAT, 8'h03);
        chk_reg(OFS_RH, 8'(res >> 8));
        wr_reg(OFS_CVH, 8'h03);
        wr_reg(OFS_CVL, 8'hFF);
        wr_reg(OFS_SC2, 8'h30);
        launch(3'b000);
        wait_idle(1'b0);
        chk_reg(OFS_SC1, {3'b000, ch});
        chk_reg(OFS_RL, 8'(res));
        wr_reg(OFS_SC2, 8'h20);
        launch(3'b000);
        wait_idle(1'b1);
        chk_res();
        wr_reg(OFS_SC2, 8'h00);
        for (int k = 0; k < 5; k++) begin
            launch(3'b000);
            tick(20);
            wr_reg(ab_a[k], ab_d[k]);
            tick(2);
            cmp1(o_core.active, 1'b0);
            chk_res();
        end
        launch(3'b000);
        tick(20);
        launch(3'b000);
        wait_idle(1'b1);
        chk_res();
        launch(3'b000);
        tick(10);
        set_stop(1'b1);
        tick(3);
        cmp1(o_core.active, 1'b0);
        set_stop(1'b0);
        chk_res();
        wr_reg(OFS_CFG, 8'h07);
        launch(3'b000);
        tick(10);
        cmp1(o_core.async_clk_en, 1'b1);
        set_stop(1'b1);
        wait_idle(1'b1);
        set_stop(1'b0);
        cmp1(o_core.async_clk_en, 1'b0);
        chk_res();
        for (int l = 0; l < 2; l++) begin
            wr_reg(OFS_CFG, l ? 8'h96 : 8'h85);
            launch(3'b000);
            tick(1);
            n = 0;
            while (o_core.sample === 1'b1 && n < 1000) begin
                tick(1);
                n++;
            end
            e = l ? 640 : 64;
            cmp1(n >= e - 1 && n <= e + 1, 1'b1);
            cmp1(o_core.low_power, 1'b1);
            wait_idle(1'b1);
            chk_res();
        end
        wr_reg(OFS_CFG, 8'h00);
        launch(3'b000);
        wait_idle(1'b0);
        chk_reg(OFS_RH, 8'h00);
        cmp1(o_core.ten_bit, 1'b0);
        launch(3'b000);
        tick(10);
        @(posedge i_sys_clk);
        i_arst_n <= 1'b0;
        tick(5);
        cmp1(o_core.active, 1'b0);
        @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        res = 10'h000;
        chk_res();
        chk_reg(OFS_SC1, 8'h1F);
        stop_test();
    end
endmodule
